/* verilog/rfb_cfg.svh */
// Constants for the registered-feedback burst master and slave ends.
// Assumes both ends share one clock and see the same code values.
// How it works
// R01: Constant burst keeps direction, select, address
// R02: Slave may acknowledge next constant beat immediately
// R03: One transfer per clock without wait states
// R04: Master waits by dropping strobe, keeping cycle
// R05: Master resumes with strobe, select, next data
// R06: Slave throttles by withholding acknowledge
// R07: Slave holds acknowledge, captures each completed write
// R08: Last beat marked end-of-burst, then all drop
// R09: Address step equals bus width in bytes
// R10: Linear burst adds one step, full carry
// R11: Wrapped burst counts low bits modulo wrap
// R12: Wrap-4 from one gives 1-2-3-0-5-6-7-4
// R13: Incrementing burst keeps direction, select; steps address
// R14: Slave may acknowledge next incrementing beat immediately
// R15: Wrapped read starts incrementing code, wrap-4, read
// R16: Read data captured as next address presented
// R17: Pipelined mode moves control one clock earlier
// R18: Classic and end-of-burst codes always supported
// R19: Burst extension codes linear, wrap 4/8/16
// R20: Transfer ends only with strobe and acknowledge
// R21: Unsupported burst types run as classic transfers
// R22: Constant and incrementing codes are parameters
`ifndef RFB_CFG_SVH
`define RFB_CFG_SVH
// ----------------------------------------
// Cycle type codes
// ----------------------------------------
`define RFB_CTI_CLASSIC 3'h0
`define RFB_CTI_CONST_DEF 3'h1
`define RFB_CTI_INCR_DEF 3'h2
`define RFB_CTI_EOB 3'h7
// ----------------------------------------
// Burst extension codes and wrap widths
// ----------------------------------------
`define RFB_BTE_LINEAR 2'h0
`define RFB_BTE_WRAP4 2'h1
`define RFB_BTE_WRAP8 2'h2
`define RFB_BTE_WRAP16 2'h3
`define RFB_WRAP4_BITS 2
`define RFB_WRAP8_BITS 3
`define RFB_WRAP16_BITS 4
// ----------------------------------------
// Data buffer
// ----------------------------------------
`define RFB_BUF_FULL 2'h2
`endif

/* verilog/rfb_pkg.sv */
// Types used by the burst master end and the bench; the slave end uses none.
// Assumes rfb_cfg.svh holds the code values.
`default_nettype none
package rfb_pkg;
	typedef enum logic [1:0] {kind_classic, kind_const, kind_incr} rfb_kind_t;
	typedef enum logic {st_idle, st_run} rfb_state_t;
endpackage : rfb_pkg
`default_nettype wire

/* verilog/rfb_bus_if.sv */
// Bus signals between one master end and one slave end.
// Assumes a single shared clock supplied to both ends.
`timescale 1ns/1ps
`default_nettype none
interface rfb_bus_if #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int SW = DW / 8
);
	logic cyc;
	logic stb;
	logic we;
	logic [AW-1:0] adr;
	logic [SW-1:0] sel;
	logic [DW-1:0] dat_m2s;
	logic [DW-1:0] dat_s2m;
	logic [2:0] cti;
	logic [1:0] bte;
	logic ack;
	logic stall;
	modport mst (output cyc, stb, we, adr, sel, dat_m2s, cti, bte,
		input dat_s2m, ack, stall);
	modport slv (input cyc, stb, we, adr, sel, dat_m2s, cti, bte,
		output dat_s2m, ack, stall);
endinterface : rfb_bus_if
`default_nettype wire

/* verilog/rfb_master.sv */
// Burst master end: runs one classic, constant or incrementing cycle.
// Assumes user logic on the same clock; read data leaves via a buffer.
`timescale 1ns/1ps
`default_nettype none
`include "rfb_cfg.svh"
module rfb_master #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int SW = DW / 8,
	parameter int LW = 8,
	parameter bit PIPELINED = 1'b0,
	parameter logic [2:0] CTI_CONST = `RFB_CTI_CONST_DEF,
	parameter logic [2:0] CTI_INCR = `RFB_CTI_INCR_DEF
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire rfb_pkg::rfb_kind_t kind_i,
	input wire logic we_i,
	input wire logic [AW-1:0] adr_i,
	input wire logic [SW-1:0] sel_i,
	input wire logic [1:0] bte_i,
	input wire logic [LW-1:0] len_i,
	output logic busy_o,
	output logic done_o,
	input wire logic wr_valid_i,
	input wire logic [DW-1:0] wr_data_i,
	output logic wr_ready_o,
	output logic rd_valid_o,
	output logic [DW-1:0] rd_data_o,
	input wire logic rd_ready_i,
	rfb_bus_if.mst bus
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (DW < 8 || DW % 8 != 0 || SW != DW / 8 || LW < 2) begin : g_bad
		$error("rfb_master: unsupported width parameters");
	end
	if (CTI_CONST == CTI_INCR || CTI_CONST == `RFB_CTI_CLASSIC ||
		CTI_CONST == `RFB_CTI_EOB || CTI_INCR == `RFB_CTI_CLASSIC ||
		CTI_INCR == `RFB_CTI_EOB) begin : g_bad_cti
		$error("rfb_master: burst codes must be distinct");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [AW-1:0] adr_next(input logic [AW-1:0] a,
		input logic [AW-1:0] s, input logic [1:0] bte);
		logic [AW-1:0] sum;
		logic [AW-1:0] mask;
		logic [AW-1:0] nxt;
		sum = a + AW'(SW); // [R09] [R10]
		unique case (bte)
			`RFB_BTE_LINEAR: mask = '1;
			`RFB_BTE_WRAP4: mask = AW'((SW << `RFB_WRAP4_BITS) - 1);
			`RFB_BTE_WRAP8: mask = AW'((SW << `RFB_WRAP8_BITS) - 1);
			`RFB_BTE_WRAP16: mask = AW'((SW << `RFB_WRAP16_BITS) - 1);
		endcase
		// Low bits wrap, upper bits frozen [R11] [R12] [R19]
		nxt = (a & ~mask) | (sum & mask);
		// Back at start offset: group done, move to next group
		// Linear mask is all ones, so this adds nothing there
		if (((sum ^ s) & mask) == '0)
			nxt = nxt + mask + AW'(1); // [R12]
		return nxt;
	endfunction : adr_next

	function automatic logic [2:0] cti_for(input rfb_pkg::rfb_kind_t k,
		input logic [LW-1:0] n);
		if (k == rfb_pkg::kind_classic)
			return `RFB_CTI_CLASSIC; // [R18]
		if (n == LW'(1))
			return `RFB_CTI_EOB; // [R08]
		if (k == rfb_pkg::kind_const)
			return CTI_CONST; // [R22]
		if (k == rfb_pkg::kind_incr)
			return CTI_INCR; // [R22] [R15]
		return `RFB_CTI_CLASSIC; // [R21]
	endfunction : cti_for

	// ----------------------------------------
	// State
	// ----------------------------------------
	rfb_pkg::rfb_state_t state_r;
	rfb_pkg::rfb_kind_t kind_r;
	logic cyc_r, stb_r, we_r, done_r;
	logic [AW-1:0] adr_r;
	logic [AW-1:0] adr0_r;
	logic [SW-1:0] sel_r;
	logic [2:0] cti_r;
	logic [1:0] bte_r;
	logic [LW-1:0] iss_r, ackl_r;
	logic [DW-1:0] dat_r;
	logic [DW-1:0] rb_mem [2];
	logic rb_wp_r, rb_rp_r;
	logic [1:0] rb_cnt_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire idle = state_r == rfb_pkg::st_idle;
	wire start_go = idle & start_i;
	wire [LW-1:0] len_eff = (len_i == '0) ? LW'(1) : len_i;
	// Standard: strobe with ack; pipelined: strobe without stall [R20] [R17]
	wire acc = stb_r & (PIPELINED ? ~bus.stall : bus.ack);
	wire got = PIPELINED ? (cyc_r & bus.ack) : (stb_r & bus.ack);
	wire last_iss = iss_r == LW'(1);
	wire fin = got & (ackl_r == LW'(1));
	wire rb_push = got & ~we_r; // [R16]
	wire rb_pop = rd_valid_o & rd_ready_i;
	wire [1:0] rb_cnt_nxt = 2'(rb_cnt_r + {1'b0, rb_push} - {1'b0, rb_pop});
	wire [LW-1:0] infl = ackl_r - iss_r;
	wire [LW-1:0] infl_nxt = LW'(infl + LW'(acc) - LW'(got));
	// Reads only go ahead if the buffer can take every pending word
	wire room = (3'(rb_cnt_nxt) + 3'(infl_nxt)) < 3'(`RFB_BUF_FULL);
	wire more = idle ? start_go
		: (acc ? ~last_iss : (~stb_r & iss_r != '0));
	wire eff_we = idle ? we_i : we_r;
	wire load_w = wr_ready_o & wr_valid_i;
	// Hold strobe until taken, else wait state when data/room lacking
	wire stb_nxt = (stb_r & ~acc) |
		(more & (eff_we ? wr_valid_i : room)); // [R04] [R05] [R03]
	assign wr_ready_o = more & eff_we;

	// ----------------------------------------
	// Cycle control
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= rfb_pkg::st_idle;
			kind_r <= rfb_pkg::kind_classic;
			cyc_r <= 1'b0;
			stb_r <= 1'b0;
			we_r <= 1'b0;
			done_r <= 1'b0;
			iss_r <= '0;
			ackl_r <= '0;
		end else if (ce_i) begin
			done_r <= fin;
			stb_r <= stb_nxt & ~fin;
			if (start_go) begin
				state_r <= rfb_pkg::st_run;
				kind_r <= kind_i;
				cyc_r <= 1'b1;
				we_r <= we_i;
				iss_r <= len_eff;
				ackl_r <= len_eff;
			end else begin
				if (acc)
					iss_r <= iss_r - LW'(1);
				if (got)
					ackl_r <= ackl_r - LW'(1);
				if (fin) begin
					state_r <= rfb_pkg::st_idle;
					cyc_r <= 1'b0; // [R08]
				end
			end
		end
	end

	// ----------------------------------------
	// Address phase
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			adr_r <= '0;
			adr0_r <= '0;
			sel_r <= '0;
			cti_r <= `RFB_CTI_CLASSIC;
			bte_r <= `RFB_BTE_LINEAR;
			dat_r <= '0;
		end else if (ce_i) begin
			if (start_go) begin
				adr_r <= adr_i;
				adr0_r <= adr_i;
				sel_r <= sel_i;
				bte_r <= bte_i;
				cti_r <= cti_for(kind_i, len_eff); // [R15]
			end else if (acc & ~last_iss) begin
				// Select and direction stay put [R01] [R13]
				if (kind_r == rfb_pkg::kind_incr)
					adr_r <= adr_next(adr_r, adr0_r, bte_r); // [R13] [R16]
				cti_r <= cti_for(kind_r, iss_r - LW'(1)); // [R08]
			end
			if (load_w)
				dat_r <= wr_data_i; // [R05]
		end
	end

	// ----------------------------------------
	// Read data buffer
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rb_wp_r <= 1'b0;
			rb_rp_r <= 1'b0;
			rb_cnt_r <= 2'h0;
		end else if (ce_i) begin
			rb_cnt_r <= rb_cnt_nxt;
			if (rb_push)
				rb_wp_r <= ~rb_wp_r;
			if (rb_pop)
				rb_rp_r <= ~rb_rp_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && rb_push)
			rb_mem[rb_wp_r] <= bus.dat_s2m; // [R16]
	end

	assign rd_valid_o = rb_cnt_r != 2'h0;
	assign rd_data_o = rb_mem[rb_rp_r];
	assign busy_o = ~idle;
	assign done_o = done_r;
	assign bus.cyc = cyc_r;
	assign bus.stb = stb_r;
	assign bus.we = we_r;
	assign bus.adr = adr_r;
	assign bus.sel = sel_r;
	assign bus.dat_m2s = dat_r;
	assign bus.cti = cti_r;
	assign bus.bte = bte_r;
endmodule : rfb_master
`default_nettype wire

/* verilog/rfb_slave.sv */
// Burst slave end: a data sink for writes and source for reads.
// Assumes user logic on the same clock on both buffer sides.
`timescale 1ns/1ps
`default_nettype none
`include "rfb_cfg.svh"
module rfb_slave #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int SW = DW / 8,
	parameter bit PIPELINED = 1'b0,
	parameter logic [2:0] CTI_CONST = `RFB_CTI_CONST_DEF,
	parameter logic [2:0] CTI_INCR = `RFB_CTI_INCR_DEF
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	output logic wr_valid_o,
	output logic [DW-1:0] wr_data_o,
	input wire logic wr_ready_i,
	input wire logic rd_valid_i,
	input wire logic [DW-1:0] rd_data_i,
	output logic rd_ready_o,
	output logic [AW-1:0] last_adr_o,
	rfb_bus_if.slv bus
);
	if (DW < 8 || DW % 8 != 0 || SW != DW / 8 ||
		CTI_CONST == CTI_INCR || CTI_CONST == `RFB_CTI_CLASSIC ||
		CTI_CONST == `RFB_CTI_EOB || CTI_INCR == `RFB_CTI_CLASSIC ||
		CTI_INCR == `RFB_CTI_EOB) begin : g_bad
		$error("rfb_slave: unsupported parameters");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic ack_r;
	logic [DW-1:0] dat_r;
	logic [AW-1:0] ladr_r;
	logic [DW-1:0] wb_mem [2];
	logic [DW-1:0] rb_mem [2];
	logic wb_wp_r, wb_rp_r, rb_wp_r, rb_rp_r;
	logic [1:0] wb_cnt_r, rb_cnt_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Other codes fall back to classic handling [R21] [R18] [R22]
	wire burst = bus.cti == CTI_CONST || bus.cti == CTI_INCR;
	wire done_std = ack_r & bus.stb; // [R20]
	wire ok_now = bus.we ? (wb_cnt_r != `RFB_BUF_FULL) : (rb_cnt_r != 2'h0);
	wire stall = PIPELINED & bus.cyc & bus.stb & ~ok_now;
	wire acc_p = bus.cyc & bus.stb & ~stall; // [R17]
	wire take = PIPELINED ? acc_p : (bus.cyc & done_std);
	wire wb_push = take & bus.we; // [R07]
	wire rb_pop = take & ~bus.we;
	wire wb_pop = wr_valid_o & wr_ready_i;
	wire rb_push = rd_valid_i & rd_ready_o;
	wire [1:0] wb_cnt_nxt = 2'(wb_cnt_r + {1'b0, wb_push} - {1'b0, wb_pop});
	wire [1:0] rb_cnt_nxt = 2'(rb_cnt_r + {1'b0, rb_push} - {1'b0, rb_pop});
	// Registered ack must already know next-cycle room or data
	wire ok_nxt = bus.we ? (wb_cnt_nxt != `RFB_BUF_FULL)
		: (rb_cnt_nxt != 2'h0); // [R06]
	// After a burst beat expect another; end-of-burst drops it [R08]
	wire want = bus.cyc & (done_std ? burst
		: (bus.stb | (ack_r & burst))); // [R02] [R14] [R07]
	wire ack_nxt = PIPELINED ? acc_p : (want & ok_nxt); // [R03]

	// ----------------------------------------
	// Acknowledge and capture
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_r <= 1'b0;
			ladr_r <= '0;
			dat_r <= '0;
		end else if (ce_i) begin
			ack_r <= ack_nxt;
			if (take)
				ladr_r <= bus.adr;
			if (rb_pop)
				dat_r <= rb_mem[rb_rp_r];
		end
	end

	// ----------------------------------------
	// Write and read buffers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wb_wp_r <= 1'b0;
			wb_rp_r <= 1'b0;
			wb_cnt_r <= 2'h0;
			rb_wp_r <= 1'b0;
			rb_rp_r <= 1'b0;
			rb_cnt_r <= 2'h0;
		end else if (ce_i) begin
			wb_cnt_r <= wb_cnt_nxt;
			rb_cnt_r <= rb_cnt_nxt;
			if (wb_push)
				wb_wp_r <= ~wb_wp_r;
			if (wb_pop)
				wb_rp_r <= ~wb_rp_r;
			if (rb_push)
				rb_wp_r <= ~rb_wp_r;
			if (rb_pop)
				rb_rp_r <= ~rb_rp_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && wb_push)
			wb_mem[wb_wp_r] <= bus.dat_m2s; // [R07]
		if (ce_i && rb_push)
			rb_mem[rb_wp_r] <= rd_data_i;
	end

	assign wr_valid_o = wb_cnt_r != 2'h0;
	assign wr_data_o = wb_mem[wb_rp_r];
	assign rd_ready_o = rb_cnt_r != `RFB_BUF_FULL;
	assign last_adr_o = ladr_r;
	assign bus.ack = ack_r;
	assign bus.stall = stall;
	// Standard mode shows the buffer head so the next word follows ack
	assign bus.dat_s2m = PIPELINED ? dat_r : rb_mem[rb_rp_r];
endmodule : rfb_slave
`default_nettype wire

/* dv/rfb_bus_asserts.sv */
// Bus checks for one master and one slave end in standard mode.
// Assumes one clock; inputs are the shared interface signals.
`timescale 1ns/1ps
`default_nettype none
module rfb_bus_asserts #(
	parameter int AW = 32,
	parameter int SW = 4,
	parameter logic [2:0] CTI_CONST = 3'h1,
	parameter logic [2:0] CTI_INCR = 3'h2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cyc,
	input wire logic stb,
	input wire logic we,
	input wire logic [AW-1:0] adr,
	input wire logic [SW-1:0] sel,
	input wire logic [2:0] cti,
	input wire logic [1:0] bte,
	input wire logic ack,
	input wire logic stall
);
	// ----
	// Checks
	// ----
	localparam int LB = $clog2(SW);
	wire logic beat = cyc && stb && ack;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_eob_drops_all: assert property (
		beat && cti == 3'h7 |=> !cyc && !stb && !ack)
		else $error("bus held after last beat");
	a_const_addr_held: assert property (
		beat && cti == CTI_CONST |=>
		$stable(adr) && $stable(we) && $stable(sel))
		else $error("constant burst changed request");
	a_linear_step: assert property (
		beat && cti == CTI_INCR && bte == 2'h0 |=>
		adr == $past(adr) + SW)
		else $error("linear step wrong");
	a_wrap4_low_count: assert property (
		beat && cti == CTI_INCR && bte == 2'h1 |=>
		adr[LB+1:LB] == $past(adr[LB+1:LB]) + 2'h1)
		else $error("wrap4 low bits wrong");
	a_incr_keeps_dir: assert property (
		beat && cti == CTI_INCR |=>
		$stable(we) && $stable(sel) && $stable(bte))
		else $error("incrementing burst changed request");
	a_wait_holds_req: assert property (
		cyc && stb && !ack |=>
		stb && $stable(adr) && $stable(cti) && $stable(we))
		else $error("request dropped before ack");
	a_classic_ack_gap: assert property (
		beat && cti == 3'h0 |=> !ack)
		else $error("classic ack not dropped");
	a_idle_no_strobe: assert property (
		!cyc |-> !stb)
		else $error("strobe outside cycle");
	a_ack_bounded: assert property (
		cyc && stb |-> ##[0:40] ack)
		else $error("ack never came");
	a_no_stall_std: assert property (
		!stall)
		else $error("stall in standard mode");
endmodule : rfb_bus_asserts
`default_nettype wire

/* dv/registered_feedback_burst_tb.sv */
// Bench: master and slave ends joined by one interface.
// Assumes standard mode; streams on both user sides run here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	n_fail++; $display("Error %0t: got %h want %h", $time, g, e); end end
module registered_feedback_burst_tb;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic start = 1'b0;
	logic we = 1'b0;
	logic thr = 1'b0;
	rfb_pkg::rfb_kind_t kind = rfb_pkg::kind_classic;
	logic [31:0] adr = 32'h0;
	logic [3:0] sel = 4'hf;
	logic [1:0] bte = 2'h0;
	logic [7:0] len = 8'h1;
	logic [1:0] tick = 2'h0;
	logic done, busy, mwr, mrv, swv, srr;
	logic mwv = 1'b0;
	logic srv = 1'b0;
	logic mrr = 1'b0;
	logic swr = 1'b0;
	logic [31:0] mwd = 32'h100;
	logic [31:0] srd = 32'h200;
	logic [31:0] exp_w = 32'h100;
	logic [31:0] exp_r = 32'h200;
	logic [31:0] mrd, swd, last_adr;
	int n_fail = 0;
	int samples_checked = 0;
	int n_w = 0;
	int n_r = 0;
	int cyc_n = 0;
	initial forever #2.5 clk_i = ~clk_i;
	rfb_bus_if bus ();
	rfb_master u_rfb_master (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.start_i(start), .kind_i(kind), .we_i(we), .adr_i(adr), .sel_i(sel),
		.bte_i(bte), .len_i(len), .busy_o(busy), .done_o(done),
		.wr_valid_i(mwv), .wr_data_i(mwd), .wr_ready_o(mwr),
		.rd_valid_o(mrv), .rd_data_o(mrd), .rd_ready_i(mrr), .bus(bus));
	rfb_slave u_rfb_slave (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.wr_valid_o(swv), .wr_data_o(swd), .wr_ready_i(swr),
		.rd_valid_i(srv), .rd_data_i(srd), .rd_ready_o(srr),
		.last_adr_o(last_adr), .bus(bus));
	rfb_bus_asserts u_rfb_bus_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.cyc(bus.cyc), .stb(bus.stb), .we(bus.we), .adr(bus.adr),
		.sel(bus.sel), .cti(bus.cti), .bte(bus.bte), .ack(bus.ack),
		.stall(bus.stall));
	// ----
	// User streams; sources hold valid until taken
	// ----
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + (bus.cyc ? 1 : 0);
		tick <= tick + 2'h1;
		// Sources stay quiet in reset; ready is high there
		mwv <= rst_b_i && ((mwv && !mwr) || !thr || tick[0]);
		srv <= rst_b_i && ((srv && !srr) || !thr || tick[1]);
		swr <= !thr || tick[0];
		mrr <= !thr || tick[1];
		if (mwv && mwr) mwd <= mwd + 32'h1;
		if (srv && srr) srd <= srd + 32'h1;
		if (swv && swr) begin
			`CHK(swd, exp_w)
			exp_w <= exp_w + 32'h1;
			n_w <= n_w + 1;
		end
		if (mrv && mrr) begin
			`CHK(mrd, exp_r)
			exp_r <= exp_r + 32'h1;
			n_r <= n_r + 1;
		end
	end
	// ----
	// Tasks
	// ----
	function automatic logic [31:0] last_of(logic [31:0] a, logic [1:0] b,
		int n);
		int w;
		w = (b == 2'h0) ? 0 : (16 << (b - 1));
		if (w == 0) return a + 4 * (n - 1);
		return (a & ~(w - 1)) + ((n - 1) / (w / 4)) * w +
			((a + 4 * (n - 1)) & (w - 1));
	endfunction : last_of
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic run(input rfb_pkg::rfb_kind_t k, input logic w,
		input logic [31:0] a, input logic [1:0] b, input int n);
		int i;
		int c0;
		int e0;
		logic [31:0] ea;
		c0 = cyc_n;
		e0 = w ? n_w : n_r;
		ea = last_of(a, (k == rfb_pkg::kind_incr) ? b : 2'h0,
			(k == rfb_pkg::kind_const) ? 1 : n);
		@(posedge clk_i);
		kind <= k;
		we <= w;
		adr <= a;
		bte <= b;
		len <= 8'(n);
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		#1;
		`CHK(busy, 1'b1)
		for (i = 0; i < 300 && done !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		if (i == 300) begin
			n_fail++;
			report_and_stop();
		end
		`CHK(busy, 1'b0)
		`CHK(last_adr, ea)
		if (!thr) `CHK(cyc_n - c0, n + 1)
		for (i = 0; i < 60 && (w ? n_w : n_r) - e0 != n; i++)
			@(posedge clk_i);
		`CHK((w ? n_w : n_r) - e0, n)
		if ((w ? n_w : n_r) - e0 != n)
			report_and_stop();
		$display("test done kind %0d adr %h len %0d", k, a, n);
	endtask : run
	initial begin
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		run(rfb_pkg::kind_classic, 1'b0, 32'h80, 2'h0, 1);
		run(rfb_pkg::rfb_kind_t'(2'h3), 1'b1, 32'h84, 2'h0, 1);
		run(rfb_pkg::kind_const, 1'b1, 32'h40, 2'h0, 4);
		run(rfb_pkg::kind_incr, 1'b1, 32'h30, 2'h0, 3);
		for (int b = 0; b < 4; b++) begin
			run(rfb_pkg::kind_incr, 1'b0, 32'h14, 2'(b), 4);
		end
		thr <= 1'b1;
		run(rfb_pkg::kind_const, 1'b1, 32'h40, 2'h0, 5);
		run(rfb_pkg::kind_incr, 1'b0, 32'h4, 2'h1, 8);
		run(rfb_pkg::kind_incr, 1'b0, 32'h8, 2'h1, 1);
		report_and_stop();
	end
endmodule : registered_feedback_burst_tb
`default_nettype wire
